// [frame_fmt_pkg.sv]
// frame_fmt_pkg: constants for the word-oriented packet buffer frame layout
// assumes a 16-bit buffer word, low byte holds the earlier byte of each pair
package frame_fmt_pkg;

  localparam int unsigned WADDR_W          = 10;                 // word address width
  localparam logic [9:0]  W_STATUS         = 10'h000;            // status word index
  localparam logic [9:0]  W_COUNT          = 10'h001;            // byte count word index
  localparam logic [9:0]  W_DATA0          = 10'h002;            // first data word index
  localparam logic [10:0] DATA_MAX         = 11'h5fb;            // 1531 data bytes at most
  localparam logic [10:0] COUNT_MAX        = 11'h600;            // 1536 byte count ceiling
  localparam logic [10:0] WIRE_MAX         = 11'h5ee;            // 1518 bytes on the wire
  localparam logic [10:0] WIRE_MIN         = 11'h040;            // 64 bytes on the wire
  localparam logic [10:0] DA_LAST          = 11'h005;            // index of last address byte
  localparam logic [10:0] CNT_SAT          = 11'h7ff;            // saturation of byte counter

  // receive status word fields
  localparam int unsigned ST_ALIGN         = 15;
  localparam int unsigned ST_BCAST         = 14;
  localparam int unsigned ST_CHECKSUM_ERROR_FLAG        = 13;
  localparam int unsigned ST_ODD           = 12;
  localparam int unsigned ST_LONG          = 11;
  localparam int unsigned ST_SHORT         = 10;
  localparam int unsigned ST_HASH_LO       = 1;
  localparam int unsigned ST_GROUP         = 0;

  // control byte fields
  localparam logic [7:0]  RX_CTL_BASE      = 8'h40;              // fixed 0,1 in the top bits
  localparam int unsigned CTL_ODD          = 5;
  localparam int unsigned CTL_CRC          = 4;

  // checksum constants
  localparam logic [31:0] CRC_INIT         = 32'hffffffff;
  localparam logic [31:0] CRC_POLY_REFL    = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE      = 32'hdebb20e3;       // register after a good frame

  localparam logic [7:0]  BYTE_ONES        = 8'hff;
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;

  typedef enum logic [4:0] {
    R_IDLE = 5'b00001,
    R_DATA = 5'b00010,
    R_CTL  = 5'b00100,
    R_CNT  = 5'b01000,
    R_STAT = 5'b10000
  } rx_state_t;

  typedef enum logic [5:0] {
    T_IDLE  = 6'b000001,
    T_CNT   = 6'b000010,
    T_CTL   = 6'b000100,
    T_FETCH = 6'b001000,
    T_LO    = 6'b010000,
    T_HI    = 6'b100000
  } tx_state_t;

endpackage : frame_fmt_pkg

// [crc_if.sv]
// crc_if: signals between the frame logic and its checksum engine
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface crc_if;
  logic        clear;
  logic        en;
  logic [7:0]  data;
  logic [31:0] value;
  modport user   (output clear, output en, output data, input value);
  modport engine (input clear, input en, input data, output value);
endinterface : crc_if

// [crc32_engine.sv]
// crc32_engine: byte-wide ieee 802.3 checksum register, lsb first
// assumes clear and en come from logic on the same clock
`timescale 1ns/1ps
module crc32_engine
  import frame_fmt_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  crc_if.engine     cif
);

  logic [31:0] crc_r;
  logic [31:0] crc_nxt;

  // one byte of the reflected polynomial division
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  // next register value
  always_comb begin
    crc_nxt = crc_r;
    if (cif.clear) begin
      crc_nxt = CRC_INIT;
    end else if (cif.en) begin
      crc_nxt = crc_byte(crc_r, cif.data);
    end
  end

  // register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      crc_r <= CRC_INIT;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign cif.value = crc_r;

endmodule : crc32_engine

// [packet_buffer_frame_format.sv]
// packet_buffer_frame_format: writes received frames into the packet buffer
// and reads host-built transmit frames out of it as a byte stream
// assumes a buffer with a registered write port and a read port that answers the
// registered read address within the same cycle,
// and byte streams from logic on the same clock
`timescale 1ns/1ps

// Summary of operation
// (RULE_01) each frame holds status word, byte count word, then data, in 16-bit words
// (RULE_02) half the byte count is the word total including control byte
// (RULE_03) receive byte count is always even; odd flag marks last low byte valid
// (RULE_04) transmit byte count bit zero is read as zero
// (RULE_05) a frame never exceeds six 256-byte pages, byte count at most 1536
// (RULE_06) data starts at byte offset 4 and holds at most 1531 bytes
// (RULE_07) the host supplies every transmit byte including the source address
// (RULE_08) no station address is inserted; receive data comes only from the network
// (RULE_09) the length or type field passes through untouched as payload
// (RULE_10) the control byte sits in the upper byte of the last word
// (RULE_11) transmit odd flag set sends the byte before the control byte
// (RULE_12) per-frame checksum flag applies only when automatic checksum is suppressed
// (RULE_13) receive control byte is 0,1, odd flag, then zeros
// (RULE_14) a status word is written at the start of every received frame
// (RULE_15) alignment, broadcast and bad checksum each have their own status flag
// (RULE_16) odd length flag is set for a received odd byte count
// (RULE_17) oversize flag for frames over 1518 bytes on the wire
// (RULE_18) undersize flag for frames under 64 bytes on the wire
// (RULE_19) hash is top six checksum bits over the destination address
// (RULE_20) hash bits 5..3 pick table byte, bits 2..0 pick bit
// (RULE_21) group frames flagged; a set table bit accepts them regardless of filters
// (RULE_22) checksum is the ieee 802.3 32-bit polynomial in transmission order
module packet_buffer_frame_format
  import frame_fmt_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         rx_valid,
  input  wire logic [7:0]   rx_byte,
  input  wire logic         rx_last,
  input  wire logic         rx_align_err,
  output logic              rx_ready,
  input  wire logic [63:0]  multicast_table,
  input  wire logic         other_filter_pass,
  output logic              rx_accept,
  output logic              rx_done,
  output logic              rxb_wr_en,
  output logic [9:0]        rxb_wr_addr,
  output logic [15:0]       rxb_wr_data,
  input  wire logic         tx_start,
  input  wire logic         suppress_auto_checksum,
  output logic [9:0]        txb_rd_addr,
  input  wire logic [15:0]  txb_rd_data,
  output logic              tx_valid,
  output logic [7:0]        tx_byte,
  input  wire logic         tx_ready,
  output logic              tx_append_checksum,
  output logic              tx_busy,
  output logic              tx_done
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // word index of the byte at data position n
  function automatic logic [9:0] data_word(input logic [10:0] n);
    return W_DATA0 + 10'(n >> 1);
  endfunction : data_word

  // bit-reversed top six checksum bits, msb of the polynomial first
  function automatic logic [5:0] crc_hash(input logic [31:0] c);
    return {c[0], c[1], c[2], c[3], c[4], c[5]};
  endfunction : crc_hash

  ////////////////////////////////////////////////////////////////////////////////
  // receive side

  crc_if rx_crc ();

  crc32_engine u_crc (
    .clock (clock),
    .reset (reset),
    .cif   (rx_crc.engine)
  );

  rx_state_t   rst_r,  rst_nxt;
  logic [10:0] n_r,    n_nxt;       // bytes seen on the wire
  logic [7:0]  low_r,  low_nxt;     // pending even byte
  logic        bc_r,   bc_nxt;
  logic        grp_r,  grp_nxt;
  logic        aln_r,  aln_nxt;
  logic        hpend_r, hpend_nxt;
  logic [5:0]  hash_r, hash_nxt;
  logic        we_r,   we_nxt;
  logic [9:0]  wa_r,   wa_nxt;
  logic [15:0] wd_r,   wd_nxt;
  logic        acc_r,  acc_nxt;
  logic        done_r, done_nxt;
  logic        take;
  logic [10:0] stored;
  logic [9:0]  ctl_word;

  assign rx_ready = (rst_r == R_IDLE) || (rst_r == R_DATA);
  assign take     = rx_valid && rx_ready;
  assign stored   = (n_r > DATA_MAX) ? DATA_MAX : n_r;            // [RULE_06]
  assign ctl_word = data_word(stored);                            // [RULE_10]

  assign rx_crc.clear = (rst_r == R_STAT);
  assign rx_crc.en    = take;                                    // [RULE_22]
  assign rx_crc.data  = rx_byte;

  // next state of the receive writer
  always_comb begin
    rst_nxt   = rst_r;
    n_nxt     = n_r;
    low_nxt   = low_r;
    bc_nxt    = bc_r;
    grp_nxt   = grp_r;
    aln_nxt   = aln_r;
    hpend_nxt = 1'b0;
    hash_nxt  = hash_r;
    we_nxt    = 1'b0;
    wa_nxt    = wa_r;
    wd_nxt    = wd_r;
    acc_nxt   = acc_r;
    done_nxt  = 1'b0;
    if (hpend_r) begin
      hash_nxt = crc_hash(rx_crc.value);                          // [RULE_19]
    end
    case (rst_r)
      R_IDLE, R_DATA: begin
        if (take) begin
          rst_nxt = rx_last ? R_CTL : R_DATA;
          n_nxt   = (n_r == CNT_SAT) ? n_r : n_r + 11'h001;
          aln_nxt = aln_r | rx_align_err;
          if (n_r == 11'h000) begin
            grp_nxt = rx_byte[0];
          end
          if (n_r <= DA_LAST) begin
            bc_nxt = bc_r & (rx_byte == BYTE_ONES);
          end
          hpend_nxt = (n_r == DA_LAST);
          // network bytes stored as they come, length field included [RULE_08] [RULE_09]
          if (n_r < DATA_MAX) begin
            if (n_r[0]) begin
              we_nxt = 1'b1;
              wa_nxt = data_word(n_r);                           // [RULE_01]
              wd_nxt = {rx_byte, low_r};
            end else begin
              low_nxt = rx_byte;
            end
          end
        end
      end
      R_CTL: begin
        we_nxt  = 1'b1;
        wa_nxt  = ctl_word;
        wd_nxt  = {RX_CTL_BASE | (8'(stored[0]) << CTL_ODD),     // [RULE_13]
                   stored[0] ? low_r : BYTE_ZERO};                 // [RULE_10]
        rst_nxt = R_CNT;
      end
      R_CNT: begin
        we_nxt  = 1'b1;
        wa_nxt  = W_COUNT;
        wd_nxt  = {5'h00, ctl_word + 10'h001, 1'b0};               // [RULE_02] [RULE_03]
        rst_nxt = R_STAT;
      end
      R_STAT: begin
        we_nxt = 1'b1;
        wa_nxt = W_STATUS;                                         // [RULE_14]
        wd_nxt = 16'h0000;
        wd_nxt[ST_ALIGN]  = aln_r;                                 // [RULE_15]
        wd_nxt[ST_BCAST]  = bc_r;
        wd_nxt[ST_CHECKSUM_ERROR_FLAG] = (rx_crc.value != CRC_RESIDUE);
        wd_nxt[ST_ODD]    = n_r[0];                                // [RULE_16]
        wd_nxt[ST_LONG]   = (n_r > WIRE_MAX);                      // [RULE_17]
        wd_nxt[ST_SHORT]  = (n_r < WIRE_MIN);                      // [RULE_18]
        wd_nxt[ST_HASH_LO +: 6] = hash_r;
        wd_nxt[ST_GROUP]  = grp_r;                                 // [RULE_21]
        // hash bits 5..3 pick the table byte, 2..0 the bit in it [RULE_20]
        acc_nxt  = (grp_r && multicast_table[{hash_r[5:3], hash_r[2:0]}]) ||
                   other_filter_pass;                              // [RULE_21]
        done_nxt = 1'b1;
        n_nxt    = 11'h000;
        bc_nxt   = 1'b1;
        grp_nxt  = 1'b0;
        aln_nxt  = 1'b0;
        rst_nxt  = R_IDLE;
      end
      default: rst_nxt = R_IDLE;
    endcase
  end

  // receive registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rst_r   <= R_IDLE;
      n_r     <= 11'h000;
      low_r   <= 8'h00;
      bc_r    <= 1'b1;
      grp_r   <= 1'b0;
      aln_r   <= 1'b0;
      hpend_r <= 1'b0;
      hash_r  <= 6'h00;
      we_r    <= 1'b0;
      wa_r    <= 10'h000;
      wd_r    <= 16'h0000;
      acc_r   <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      rst_r   <= rst_nxt;
      n_r     <= n_nxt;
      low_r   <= low_nxt;
      bc_r    <= bc_nxt;
      grp_r   <= grp_nxt;
      aln_r   <= aln_nxt;
      hpend_r <= hpend_nxt;
      hash_r  <= hash_nxt;
      we_r    <= we_nxt;
      wa_r    <= wa_nxt;
      wd_r    <= wd_nxt;
      acc_r   <= acc_nxt;
      done_r  <= done_nxt;
    end
  end

  assign rxb_wr_en   = we_r;
  assign rxb_wr_addr = wa_r;
  assign rxb_wr_data = wd_r;
  assign rx_accept   = acc_r;
  assign rx_done     = done_r;

  ////////////////////////////////////////////////////////////////////////////////
  // transmit side

  tx_state_t   tst_r, tst_nxt;
  logic [9:0]  last_r, last_nxt;    // index of the control word
  logic [9:0]  idx_r,  idx_nxt;
  logic [9:0]  ra_r,   ra_nxt;
  logic [15:0] hold_r, hold_nxt;
  logic        odd_r,  odd_nxt;
  logic        app_r,  app_nxt;
  logic [7:0]  tb_r,   tb_nxt;
  logic        tdone_r, tdone_nxt;
  logic [10:0] tcount;

  // stored count with bit zero forced low and clamped to the page limit
  assign tcount = (txb_rd_data[10:0] > COUNT_MAX) ? COUNT_MAX :
                  {txb_rd_data[10:1], 1'b0};                      // [RULE_04] [RULE_05]

  // next state of the transmit reader
  always_comb begin
    tst_nxt   = tst_r;
    last_nxt  = last_r;
    idx_nxt   = idx_r;
    ra_nxt    = ra_r;
    hold_nxt  = hold_r;
    odd_nxt   = odd_r;
    app_nxt   = app_r;
    tb_nxt    = tb_r;
    tdone_nxt = 1'b0;
    case (tst_r)
      T_IDLE: begin
        if (tx_start) begin
          ra_nxt  = W_COUNT;
          tst_nxt = T_CNT;
        end
      end
      T_CNT: begin
        last_nxt = 10'(tcount >> 1) - 10'h001;                    // [RULE_02]
        ra_nxt   = 10'(tcount >> 1) - 10'h001;
        tst_nxt  = T_CTL;
      end
      T_CTL: begin
        odd_nxt = txb_rd_data[8 + CTL_ODD];                        // [RULE_10]
        app_nxt = !suppress_auto_checksum || txb_rd_data[8 + CTL_CRC]; // [RULE_12]
        idx_nxt = W_DATA0;
        ra_nxt  = W_DATA0;
        if (last_r < W_DATA0 || (last_r == W_DATA0 && !txb_rd_data[8 + CTL_ODD])) begin
          tdone_nxt = 1'b1;
          tst_nxt   = T_IDLE;
        end else begin
          tst_nxt = T_FETCH;
        end
      end
      T_FETCH: begin
        // host bytes sent as stored, no address substituted [RULE_07] [RULE_08] [RULE_09]
        hold_nxt = txb_rd_data;
        tb_nxt   = txb_rd_data[7:0];
        tst_nxt  = T_LO;
      end
      T_LO: begin
        if (tx_ready) begin
          if (idx_r == last_r) begin
            tdone_nxt = 1'b1;
            tst_nxt   = T_IDLE;
          end else begin
            tb_nxt  = hold_r[15:8];
            tst_nxt = T_HI;
          end
        end
      end
      T_HI: begin
        if (tx_ready) begin
          idx_nxt = idx_r + 10'h001;
          ra_nxt  = idx_r + 10'h001;
          // the last byte before the control byte only goes out when odd [RULE_11]
          if (idx_r + 10'h001 == last_r && !odd_r) begin
            tdone_nxt = 1'b1;
            tst_nxt   = T_IDLE;
          end else begin
            tst_nxt = T_FETCH;
          end
        end
      end
      default: tst_nxt = T_IDLE;
    endcase
  end

  // transmit registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tst_r   <= T_IDLE;
      last_r  <= 10'h000;
      idx_r   <= 10'h000;
      ra_r    <= 10'h000;
      hold_r  <= 16'h0000;
      odd_r   <= 1'b0;
      app_r   <= 1'b0;
      tb_r    <= 8'h00;
      tdone_r <= 1'b0;
    end else begin
      tst_r   <= tst_nxt;
      last_r  <= last_nxt;
      idx_r   <= idx_nxt;
      ra_r    <= ra_nxt;
      hold_r  <= hold_nxt;
      odd_r   <= odd_nxt;
      app_r   <= app_nxt;
      tb_r    <= tb_nxt;
      tdone_r <= tdone_nxt;
    end
  end

  assign txb_rd_addr        = ra_r;
  assign tx_valid           = (tst_r == T_LO) || (tst_r == T_HI);
  assign tx_byte            = tb_r;
  assign tx_append_checksum = app_r;
  assign tx_busy            = (tst_r != T_IDLE);
  assign tx_done            = tdone_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  a_rx_count_even: assert property (@(posedge clock) disable iff (reset)   // [RULE_03]
    (we_r && wa_r == W_COUNT) |-> (wd_r[0] == 1'b0 && wd_r[10:0] <= COUNT_MAX))
    else $error("receive byte count odd or too large");

  a_rx_ctl_pattern: assert property (@(posedge clock) disable iff (reset)  // [RULE_13]
    (rst_r == R_CTL) |=> (wd_r[15:14] == 2'b01 && wd_r[12:8] == 5'h00
                          && wd_r[13] == $past(stored[0])))
    else $error("receive control byte pattern wrong");

  a_rx_status_seq: assert property (@(posedge clock) disable iff (reset)   // [RULE_14]
    (rst_r == R_DATA && take && rx_last) |=> ##2 (we_r && wa_r == W_COUNT)
                                          ##1 (we_r && wa_r == W_STATUS && rx_done))
    else $error("status word not written after frame");

  a_rx_short_flag: assert property (@(posedge clock) disable iff (reset)   // [RULE_18]
    (rst_r == R_STAT) |=> (wd_r[ST_SHORT] == ($past(n_r) < WIRE_MIN)
                           && wd_r[ST_LONG] == ($past(n_r) > WIRE_MAX)))
    else $error("length flags disagree with byte count");

  a_rx_odd_flag: assert property (@(posedge clock) disable iff (reset)     // [RULE_16]
    (rst_r == R_STAT) |=> (wd_r[ST_ODD] == $past(n_r[0])))
    else $error("odd length flag wrong");

  a_rx_data_limit: assert property (@(posedge clock) disable iff (reset)   // [RULE_06]
    (we_r && rst_r == R_DATA) |-> (wa_r >= W_DATA0 && wa_r < W_DATA0 + 10'(DATA_MAX >> 1) + 10'h001))
    else $error("data word written outside data area");

  a_tx_checksum_sel: assert property (@(posedge clock) disable iff (reset) // [RULE_12]
    (tst_r == T_CTL) |=> (tx_append_checksum ==
                          (!$past(suppress_auto_checksum) || $past(txb_rd_data[8 + CTL_CRC]))))
    else $error("append checksum selection wrong");

  a_tx_count_lsb: assert property (@(posedge clock) disable iff (reset)    // [RULE_04]
    (tst_r == T_CNT) |=> (txb_rd_addr == 10'($past(tcount) >> 1) - 10'h001
                          && last_r == txb_rd_addr))
    else $error("control word index not from masked count");

  a_tx_no_ctl_byte: assert property (@(posedge clock) disable iff (reset)  // [RULE_11]
    (tst_r == T_HI && tx_ready && idx_r + 10'h001 == last_r && !odd_r) |=> tx_done)
    else $error("byte before control byte sent while even");

endmodule : packet_buffer_frame_format

// [host_buffer_model.sv]
// host_buffer_model: host side of the packet buffer, one transmit and one receive frame
// assumes the framer registers its read address, so reads answer within the cycle,
// and a registered write strobe from the framer
`timescale 1ns/1ps
module host_buffer_model (
  input  wire logic        clock,
  input  wire logic [9:0]  txb_rd_addr,
  output logic      [15:0] txb_rd_data,
  input  wire logic        rxb_wr_en,
  input  wire logic [9:0]  rxb_wr_addr,
  input  wire logic [15:0] rxb_wr_data
);
  // host-built frame: status, count, data, control; host writes every data byte
  logic [15:0] tx_mem [0:1023];
  logic [15:0] rx_mem [0:1023]; // words landed by the receive side
  //////////////////////////////////////////////////////////////////////////////
  // read port, data follows the registered address in the same cycle
  assign txb_rd_data = tx_mem[txb_rd_addr];
  // capture of receive words
  always_ff @(posedge clock) begin
    if (rxb_wr_en) begin
      rx_mem[rxb_wr_addr] <= rxb_wr_data;
    end
  end
endmodule : host_buffer_model

// [packet_buffer_frame_format_test.sv]
// packet_buffer_frame_format_test: receive layout, flags, hash and transmit unpacking
// assumes the host model answers a registered read address within the cycle
`timescale 1ns/1ps
module packet_buffer_frame_format_test;
  import frame_fmt_pkg::*;
  logic        clock, reset, rx_valid, rx_last, rx_align_err, other_filter_pass;
  logic        rx_ready, rx_accept, rx_done, rxb_wr_en, tx_start, suppress_auto_checksum;
  logic        tx_valid, tx_ready, tx_append_checksum, tx_busy, tx_done;
  logic [7:0]  rx_byte, tx_byte;
  logic [63:0] multicast_table;
  logic [9:0]  rxb_wr_addr, txb_rd_addr;
  logic [15:0] rxb_wr_data, txb_rd_data;
  int          n_mismatch = 0;
  int          n_tests = 0;
  logic [7:0]  q [$];
  logic [7:0]  da [4] = '{8'hed, 8'h0d, 8'h01, 8'h2f};
  logic [5:0]  hv [4] = '{6'h00, 6'h10, 6'h27, 6'h3f};
  //////////////////////////////////////////////////////////////////////////////
  // design and host model
  packet_buffer_frame_format i_packet_buffer_frame_format (.clock(clock), .reset(reset),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last), .rx_align_err(rx_align_err),
    .rx_ready(rx_ready), .multicast_table(multicast_table),
    .other_filter_pass(other_filter_pass), .rx_accept(rx_accept), .rx_done(rx_done),
    .rxb_wr_en(rxb_wr_en), .rxb_wr_addr(rxb_wr_addr), .rxb_wr_data(rxb_wr_data),
    .tx_start(tx_start), .suppress_auto_checksum(suppress_auto_checksum),
    .txb_rd_addr(txb_rd_addr), .txb_rd_data(txb_rd_data), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_ready(tx_ready), .tx_append_checksum(tx_append_checksum),
    .tx_busy(tx_busy), .tx_done(tx_done));
  host_buffer_model i_host_buffer_model (.clock(clock), .txb_rd_addr(txb_rd_addr),
    .txb_rd_data(txb_rd_data), .rxb_wr_en(rxb_wr_en), .rxb_wr_addr(rxb_wr_addr),
    .rxb_wr_data(rxb_wr_data));
  //////////////////////////////////////////////////////////////////////////////
  // clock at 4 ns
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // frame bytes: first, five address fill bytes, then a running pattern
  task automatic make_q(input logic [7:0] first, input logic [7:0] fill, input int n);
    q.delete();
    for (int i = 0; i < n; i++) begin
      q.push_back(i == 0 ? first : (i < 6 ? fill : 8'(i) + 8'h10));
    end
  endtask : make_q
  // one byte per cycle, then wait for the status write
  task automatic rx_send(input logic aerr);
    int i;
    int nb;
    @(posedge clock);
    for (i = 0; i < q.size(); i++) begin
      rx_valid     <= 1'b1;
      rx_byte      <= q[i];
      rx_last      <= (i == q.size() - 1);
      rx_align_err <= aerr;
      @(posedge clock);
    end
    rx_valid     <= 1'b0;
    rx_last      <= 1'b0;
    rx_align_err <= 1'b0;
    i  = 0;
    nb = 0;
    @(negedge clock);
    while (rx_done !== 1'b1 && i < 20) begin
      nb += (rx_ready === 1'b0);
      @(negedge clock);
      i++;
    end
    check(i < 20, 1, "rx_done wait");
    check(nb, 3, "write-back refusal");
    @(negedge clock);
  endtask : rx_send
  // lengths around the undersize and oversize bounds
  task automatic test_lengths();
    int n [4] = '{63, 64, 1518, 1519};
    int c;
    for (int k = 0; k < 4; k++) begin
      make_q(8'h10, 8'h11, n[k]);
      rx_send(k == 0);
      c = (n[k] + 6) & ~1;
      check(i_host_buffer_model.rx_mem[1], c, "count");
      check(i_host_buffer_model.rx_mem[2], {q[1], q[0]}, "first word");
      check(i_host_buffer_model.rx_mem[c / 2 - 1][15:8], 8'h40 | (n[k] % 2) << 5, "ctl");
      check(i_host_buffer_model.rx_mem[0] & 16'hfc01, {k == 0, 2'b01, n[k] % 2 == 1,
        n[k] > 1518, n[k] < 64, 10'h0}, "status");
    end
    $display("test lengths done");
  endtask : test_lengths
  // group addresses: hash value and table acceptance
  task automatic test_group();
    for (int k = 0; k < 8; k++) begin
      multicast_table <= (k < 4) ? 64'h1 << hv[k % 4] : ~(64'h1 << hv[k % 4]);
      make_q(da[k % 4], 8'h00, 14);
      rx_send(1'b0);
      check(i_host_buffer_model.rx_mem[0], 16'h2401 | {hv[k % 4], 1'b0}, "hash");
      check(rx_accept, k < 4, "accept");
      check(i_host_buffer_model.rx_mem[1], 16'h0014, "count");
      check(i_host_buffer_model.rx_mem[8], {q[13], q[12]}, "type");
      check(i_host_buffer_model.rx_mem[9][15:8], 8'h40, "ctl");
    end
    $display("test group done");
  endtask : test_group
  // all-ones destination
  task automatic test_broadcast();
    make_q(8'hff, 8'hff, 14);
    rx_send(1'b0);
    check(i_host_buffer_model.rx_mem[0] & 16'hfc01, 16'h6401, "bcast");
    $display("test broadcast done");
  endtask : test_broadcast
  // odd and even transmit frames with a stalling sink
  task automatic test_tx();
    logic [7:0] got [$];
    logic       app;
    logic       busy;
    bit         done;
    for (int k = 0; k < 3; k++) begin
      i_host_buffer_model.tx_mem[1] = 16'h000b; // stray count bit zero
      i_host_buffer_model.tx_mem[2] = 16'hb2a1;
      i_host_buffer_model.tx_mem[3] = 16'hd4c3;
      i_host_buffer_model.tx_mem[4] = {k == 0 ? 8'h30 : (k == 1 ? 8'h00 : 8'h10), 8'he5};
      i_host_buffer_model.tx_mem[5] = 16'hffff;
      got.delete();
      done = 0;
      @(posedge clock);
      suppress_auto_checksum <= (k != 2);
      tx_start <= 1'b1;
      @(posedge clock);
      tx_start <= 1'b0;
      for (int i = 0; i < 200 && !done; i++) begin
        @(negedge clock);
        if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_byte);
        if (tx_done === 1'b1) begin
          app = tx_append_checksum;
          busy = tx_busy;
          done = 1;
        end
        @(posedge clock);
        tx_ready <= (i % 3 != 0);
      end
      check(got.size(), k == 0 ? 5 : 4, "tx length");
      check(busy, 1'b0, "idle at done");
      for (int i = 0; i < got.size() && i < 5; i++) begin
        check(got[i], 8'ha1 + 8'h11 * i, "tx byte");
      end
      check(app, k != 1, "append");
    end
    $display("test tx done");
  endtask : test_tx
  // main sequence
  initial begin
    reset = 1'b1;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_last = 1'b0;
    rx_align_err = 1'b0;
    other_filter_pass = 1'b0;
    multicast_table = 64'h0;
    tx_start = 1'b0;
    suppress_auto_checksum = 1'b0;
    tx_ready = 1'b1;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    test_lengths();
    test_group();
    test_broadcast();
    test_tx();
    print_verdict();
  end
  // watchdog, about six times the expected run
  initial begin
    #80000;
    n_mismatch++;
    print_verdict();
  end
endmodule : packet_buffer_frame_format_test
